/* File: rtl/qxsm_cfg.svh */
// Purpose: Constants of the quad transceiver serial management link.
// Assumes: One master clock at 50 MHz drives both ends.
// Notes: Field positions count line characters from the frame start.
`ifndef QXSM_CFG_SVH
`define QXSM_CFG_SVH

`define QXSM_CLK_MHZ 50
`define QXSM_BIT_CLKS 4
`define QXSM_CHAR_BITS 2
`define QXSM_CHAR_LAST 3'h7
`define QXSM_FRAME_LAST 5'h1c
`define QXSM_DEV_SAMPLE 3'h3
`define QXSM_CTL_SAMPLE 3'h5
`define QXSM_PREAMBLE 5'h0a
`define QXSM_STAT_LAST 5'h14
`define QXSM_CMD_LAST 5'h15
`define QXSM_POS_ID 5
`define QXSM_POS_LINK 9
`define QXSM_POS_POL 13
`define QXSM_POS_JAB 17
`define QXSM_POS_E 0
`define QXSM_POS_F 4
`define QXSM_POS_G 8
`define QXSM_POS_H 12
`define QXSM_POS_I 16
`define QXSM_POS_J 17
`define QXSM_POS_K 21
`define QXSM_LP_IDLE_MS 16
`define QXSM_LP_IDLE_CYC (`QXSM_LP_IDLE_MS * 1000 * `QXSM_CLK_MHZ)
`define QXSM_RST_EXT 4'h0
`define QXSM_RST_LT 4'hf
`define QXSM_RST_LP 4'hf
`define QXSM_RST_APOL_DIS 4'hf
`define QXSM_RST_LOOP_DIS 1'h1
`define QXSM_RST_NORMAL 4'hf
`define QXSM_RST_PSEUDO 1'h1
`define QXSM_RST_LINK 4'h0
`define QXSM_RST_POL 4'hf
`define QXSM_RST_JAB 4'h0

`endif

/* File: rtl/qxsm_pkg.sv */
// Purpose: Types shared by both ends of the management link.
// Assumes: Constants come from qxsm_cfg.svh.
// Notes: All state of qxsm_dev and qxsm_ctl is held in the structs below.
package qxsm_pkg;

    typedef logic [3:0] qxsm_port_t;

    typedef enum logic [1:0] {QXSM_IDLE, QXSM_STAT, QXSM_CMD} qxsm_state_e;

    typedef struct packed {
        logic dir_q;
        qxsm_state_e st;
        logic [2:0] bcnt;
        logic [4:0] ccnt;
        logic [21:0] shadow;
        logic sd;
        qxsm_port_t link;
        qxsm_port_t pol;
        qxsm_port_t jab;
        qxsm_port_t ext;
        qxsm_port_t lt_en;
        qxsm_port_t lp_en;
        qxsm_port_t apol_dis;
        logic loop_dis;
        qxsm_port_t normal;
        logic pseudo;
        logic [3:0][19:0] idle;
        qxsm_port_t pulse;
    } qxsm_dev_s;

    typedef struct packed {
        logic dir;
        logic [2:0] bcnt;
        logic [4:0] ccnt;
        logic [21:0] cmd;
        logic sd;
        logic [20:0] rx;
        logic [3:0] id;
        qxsm_port_t link;
        qxsm_port_t pol;
        qxsm_port_t jab;
        logic valid;
        logic pre_err;
    } qxsm_ctl_s;

endpackage

/* File: rtl/qxsm_if.sv */
// Purpose: Serial management link between transceiver and controller.
// Assumes: Both ends run on the same master clock.
// Notes: The shared line is pulled high when nobody drives it.
`timescale 1ns/1ps
interface qxsm_if;
    logic dir;
    logic dev_do;
    logic dev_oe;
    logic ctl_do;
    logic ctl_oe;
    logic mgmt_serial_line;

    // A contention would show as the device's value; the ends avoid it.
    assign mgmt_serial_line = dev_oe ? dev_do : (ctl_oe ? ctl_do : 1'b1);

    modport dev (input dir, input mgmt_serial_line,
                 output dev_do, output dev_oe);
    modport ctl (output dir, input mgmt_serial_line,
                 output ctl_do, output ctl_oe);
endinterface

/* File: rtl/qxsm_dev.sv */
// Purpose: Transceiver end: status sender and command receiver.
// Assumes: Direction and line are synchronous to i_ref_clk.
// Notes: Detection of link, polarity and jabber happens outside.
`timescale 1ns/1ps
`include "qxsm_cfg.svh"
module qxsm_dev #(
    parameter int unsigned LP_IDLE_CYC = `QXSM_LP_IDLE_CYC,
    parameter logic [3:0] DEV_ID = 4'h5 // Arbitrary value.
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_xcvr_rst_n,
    qxsm_if.dev bus,
    input wire qxsm_pkg::qxsm_port_t i_link_det,
    input wire qxsm_pkg::qxsm_port_t i_pol_true,
    input wire qxsm_pkg::qxsm_port_t i_jabber,
    input wire qxsm_pkg::qxsm_port_t i_tx_act,
    output logic [3:0] o_ext_dist,
    output logic [3:0] o_link_test_en,
    output logic [3:0] o_link_pulse_en,
    output logic [3:0] o_auto_pol_dis,
    output logic o_loopback_dis,
    output logic [3:0] o_mode_normal,
    output logic o_pseudo_attach_levels,
    output logic [3:0] o_link_pulse
);
    import qxsm_pkg::*;

    qxsm_dev_s s_ff;
    qxsm_dev_s nxt_s;

    // Status fields of a frame, first line character in bit 0.
    function automatic logic [20:0] stat_word(input qxsm_dev_s st);
        stat_word = {st.jab, st.pol, st.link, DEV_ID, `QXSM_PREAMBLE};
    endfunction

    // Status character at a frame position, ones past the last field.
    function automatic logic stat_bit(input logic [4:0] idx,
                                      input qxsm_dev_s st);
        logic [20:0] vec;
        vec = stat_word(st);
        if (idx <= `QXSM_STAT_LAST)
        begin
            stat_bit = vec[idx];
        end
        else
        begin
            stat_bit = 1'b1;
        end
    endfunction

    // True on the last clock of a line character.
    function automatic logic char_end(input logic [2:0] cnt);
        char_end = (cnt == `QXSM_CHAR_LAST);
    endfunction

    // Live settings take a whole command frame at once, never a part.
    function automatic qxsm_dev_s apply_cmd(input qxsm_dev_s cur,
                                            input logic [21:0] w);
        qxsm_dev_s r;
        r = cur;
        r.ext = w[`QXSM_POS_E +: 4];
        r.lt_en = w[`QXSM_POS_F +: 4];
        r.lp_en = w[`QXSM_POS_G +: 4];
        r.apol_dis = w[`QXSM_POS_H +: 4];
        r.loop_dis = w[`QXSM_POS_I];
        r.normal = w[`QXSM_POS_J +: 4];
        r.pseudo = w[`QXSM_POS_K];
        return r;
    endfunction

    // Defaults shared by both resets. The line driver rests high so a
    // released line never shows a stray low character.
    function automatic qxsm_dev_s reset_state();
        qxsm_dev_s r;
        r = '0;
        r.st = QXSM_IDLE;
        r.sd = 1'b1;
        r.link = `QXSM_RST_LINK;
        r.pol = `QXSM_RST_POL;
        r.jab = `QXSM_RST_JAB;
        r.ext = `QXSM_RST_EXT;
        r.lt_en = `QXSM_RST_LT;
        r.lp_en = `QXSM_RST_LP;
        r.apol_dis = `QXSM_RST_APOL_DIS;
        r.loop_dis = `QXSM_RST_LOOP_DIS;
        r.normal = `QXSM_RST_NORMAL;
        r.pseudo = `QXSM_RST_PSEUDO;
        return r;
    endfunction

    always_comb
    begin
        logic [21:0] sh;
        logic rise;
        logic fall;
        sh = s_ff.shadow;
        rise = bus.dir && !s_ff.dir_q;
        fall = !bus.dir && s_ff.dir_q;
        nxt_s = s_ff;
        if (i_ce)
        begin
            nxt_s.dir_q = bus.dir;
            nxt_s.link = i_link_det | ~s_ff.lt_en;
            nxt_s.pol = i_pol_true;
            nxt_s.jab = i_jabber;
            // Counters restart on every edge, so a cut frame is dropped.
            if (rise)
            begin
                nxt_s.st = QXSM_CMD;
                nxt_s.bcnt = 3'h0;
                nxt_s.ccnt = 5'h00;
            end
            else if (fall)
            begin
                nxt_s.st = QXSM_STAT;
                nxt_s.bcnt = 3'h0;
                nxt_s.ccnt = 5'h00;
                nxt_s.sd = stat_bit(5'h00, s_ff);
            end
            else
            begin
                unique case (s_ff.st)
                    QXSM_IDLE:
                    begin
                        nxt_s.bcnt = 3'h0;
                    end
                    QXSM_STAT:
                    begin
                        nxt_s.bcnt = s_ff.bcnt + 3'h1;
                        if (char_end(s_ff.bcnt))
                        begin
                            nxt_s.ccnt = s_ff.ccnt + 5'h01;
                            nxt_s.sd = stat_bit(s_ff.ccnt + 5'h01, s_ff);
                            if (s_ff.ccnt == `QXSM_FRAME_LAST)
                            begin
                                nxt_s.st = QXSM_IDLE;
                            end
                        end
                    end
                    QXSM_CMD:
                    begin
                        nxt_s.bcnt = s_ff.bcnt + 3'h1;
                        if (char_end(s_ff.bcnt))
                        begin
                            nxt_s.ccnt = s_ff.ccnt + 5'h01;
                        end
                        if (s_ff.bcnt == `QXSM_DEV_SAMPLE)
                        begin
                            sh[s_ff.ccnt] = bus.mgmt_serial_line;
                            nxt_s.shadow = sh;
                            // Settings change only on a whole frame.
                            if (s_ff.ccnt == `QXSM_CMD_LAST)
                            begin
                                nxt_s = apply_cmd(nxt_s, sh);
                                nxt_s.st = QXSM_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        nxt_s.st = QXSM_IDLE;
                    end
                endcase
            end
            for (int p = 0; p < 4; p++)
            begin
                nxt_s.pulse[p] = 1'b0;
                if (i_tx_act[p] || s_ff.pulse[p])
                begin
                    nxt_s.idle[p] = 20'h00000;
                end
                else if (s_ff.idle[p] == 20'(LP_IDLE_CYC - 1))
                begin
                    nxt_s.pulse[p] = s_ff.lp_en[p];
                    nxt_s.idle[p] = 20'h00000;
                end
                else
                begin
                    nxt_s.idle[p] = s_ff.idle[p] + 20'h00001;
                end
            end
        end
        // Reset wins over the clock enable so a frozen part still clears.
        if (i_reset || !i_xcvr_rst_n)
        begin
            nxt_s = reset_state();
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        s_ff <= nxt_s;
    end

    // Dropping the driver on the direction level itself avoids one cycle
    // of contention with the controller after a rising edge.
    assign bus.dev_oe = (s_ff.st == QXSM_STAT) && !bus.dir;
    assign bus.dev_do = s_ff.sd;
    assign o_ext_dist = s_ff.ext;
    assign o_link_test_en = s_ff.lt_en;
    assign o_link_pulse_en = s_ff.lp_en;
    assign o_auto_pol_dis = s_ff.apol_dis;
    assign o_loopback_dis = s_ff.loop_dis;
    assign o_mode_normal = s_ff.normal;
    assign o_pseudo_attach_levels = s_ff.pseudo;
    assign o_link_pulse = s_ff.pulse;
endmodule

/* File: rtl/qxsm_ctl.sv */
// Purpose: Controller end: toggles direction, sends commands, reads status.
// Assumes: Runs on the same master clock as the transceiver.
// Notes: Each phase lasts 29 characters of 8 clocks.
`timescale 1ns/1ps
`include "qxsm_cfg.svh"
module qxsm_ctl (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    qxsm_if.ctl bus,
    input wire qxsm_pkg::qxsm_port_t i_ext_dist,
    input wire qxsm_pkg::qxsm_port_t i_link_test_en,
    input wire qxsm_pkg::qxsm_port_t i_link_pulse_en,
    input wire qxsm_pkg::qxsm_port_t i_auto_pol_dis,
    input wire logic i_loopback_dis,
    input wire qxsm_pkg::qxsm_port_t i_mode_normal,
    input wire logic i_pseudo_attach_levels,
    output logic [3:0] o_dev_id,
    output logic [3:0] o_link,
    output logic [3:0] o_pol,
    output logic [3:0] o_jab,
    output logic o_status_valid,
    output logic o_preamble_err
);
    import qxsm_pkg::*;

    qxsm_ctl_s s_ff;
    qxsm_ctl_s nxt_s;

    function automatic logic cmd_bit(input logic [4:0] idx,
                                     input logic [21:0] w);
        if (idx <= `QXSM_CMD_LAST)
        begin
            cmd_bit = w[idx];
        end
        else
        begin
            cmd_bit = 1'b1;
        end
    endfunction

    always_comb
    begin
        logic [21:0] w;
        logic [20:0] r;
        w = {i_pseudo_attach_levels, i_mode_normal, i_loopback_dis,
             i_auto_pol_dis, i_link_pulse_en, i_link_test_en, i_ext_dist};
        r = s_ff.rx;
        nxt_s = s_ff;
        if (i_ce)
        begin
            nxt_s.valid = 1'b0;
            nxt_s.bcnt = s_ff.bcnt + 3'h1;
            if (s_ff.bcnt == `QXSM_CHAR_LAST)
            begin
                nxt_s.ccnt = s_ff.ccnt + 5'h01;
                nxt_s.sd = cmd_bit(s_ff.ccnt + 5'h01, s_ff.cmd);
                if (s_ff.ccnt == `QXSM_FRAME_LAST)
                begin
                    nxt_s.dir = !s_ff.dir;
                    nxt_s.ccnt = 5'h00;
                    nxt_s.cmd = w;
                    nxt_s.sd = cmd_bit(5'h00, w);
                end
            end
            if (!s_ff.dir && s_ff.bcnt == `QXSM_CTL_SAMPLE &&
                s_ff.ccnt <= `QXSM_STAT_LAST)
            begin
                r[s_ff.ccnt] = bus.mgmt_serial_line;
                nxt_s.rx = r;
                if (s_ff.ccnt == `QXSM_STAT_LAST)
                begin
                    nxt_s.valid = 1'b1;
                    nxt_s.pre_err = r[4:0] != `QXSM_PREAMBLE;
                    nxt_s.id = r[`QXSM_POS_ID +: 4];
                    nxt_s.link = r[`QXSM_POS_LINK +: 4];
                    nxt_s.pol = r[`QXSM_POS_POL +: 4];
                    nxt_s.jab = r[`QXSM_POS_JAB +: 4];
                end
            end
        end
        if (i_reset)
        begin
            nxt_s = '0;
            nxt_s.sd = 1'b1;
            nxt_s.pol = `QXSM_RST_POL;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        s_ff <= nxt_s;
    end

    assign bus.dir = s_ff.dir;
    assign bus.ctl_oe = s_ff.dir;
    assign bus.ctl_do = s_ff.sd;
    assign o_dev_id = s_ff.id;
    assign o_link = s_ff.link;
    assign o_pol = s_ff.pol;
    assign o_jab = s_ff.jab;
    assign o_status_valid = s_ff.valid;
    assign o_preamble_err = s_ff.pre_err;
endmodule

/* File: tb/qxsm_checker.sv */
// Purpose: Concurrent checks on the serial management link.
// Assumes: Both ends share i_ref_clk; offsets count from a direction edge.
// Notes: Device reset also masks checks, as it aborts a frame on purpose.
`timescale 1ns/1ps
module qxsm_checker #(
    parameter logic [3:0] DEV_ID = 4'h6 // Arbitrary value.
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_xcvr_rst_n,
    input wire logic dir,
    input wire logic dev_do,
    input wire logic dev_oe,
    input wire logic ctl_do,
    input wire logic ctl_oe,
    input wire logic mgmt_serial_line
);
    typedef struct packed {
        logic d;
        logic [8:0] run;
    } qxsm_chk_s;
    qxsm_chk_s st_ff;
    qxsm_chk_s nxt_st;

    // The first run after reset saturates, since its start is not framed.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.d = dir;
        if (dir != st_ff.d)
            nxt_st.run = 9'h001;
        else if (st_ff.run != 9'h1ff)
            nxt_st.run = st_ff.run + 9'h001;
        if (i_reset)
            nxt_st = '{d: 1'b0, run: 9'h1ff};
    end

    always_ff @(posedge i_ref_clk)
        st_ff <= nxt_st;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset || !i_xcvr_rst_n);

    a_oe_dir_low: assert property (dev_oe |-> !dir)
        else $error("device drives the line in command phase");
    a_oe_start: assert property ($fell(dir) |=> dev_oe)
        else $error("status frame did not start");
    a_preamble_bits: assert property ($fell(dir) |=> !dev_do[*8] ##1
        dev_do[*8] ##1 !dev_do[*8] ##1 dev_do[*8] ##1 !dev_do[*8])
        else $error("status preamble wrong");
    a_id_field: assert property ($fell(dir) |-> ##41
        (dev_do == DEV_ID[0])[*8] ##1 (dev_do == DEV_ID[1])[*8] ##1
        (dev_do == DEV_ID[2])[*8] ##1 (dev_do == DEV_ID[3])[*8])
        else $error("identity field wrong");
    a_trail_ones: assert property ($fell(dir) |-> ##169 dev_do[*8]
        ##55 (dev_oe && dev_do) ##1 !dev_oe)
        else $error("trailing ones or release wrong");
    a_no_clash: assert property (!(dev_oe && ctl_oe))
        else $error("both ends drive the line");
    a_cmd_tail: assert property ($rose(dir) |-> ##176
        (ctl_oe && ctl_do && mgmt_serial_line)[*8])
        else $error("command tail not high");
    a_dir_hold: assert property ((dir != st_ff.d) |->
        (st_ff.run >= 9'h0e8))
        else $error("direction level held too briefly");

    c_status: cover property ($fell(dir) ##1 dev_oe);
    c_command: cover property ($rose(dir) ##1 ctl_oe);
    c_low_bit: cover property (dev_oe && !dev_do);
endmodule

/* File: tb/quad_xcvr_serial_mgmt_test.sv */
// Purpose: Drives both link ends and checks status and command transfer.
// Assumes: Status inputs change only while commands flow, so frames agree.
// Notes: Link pulse idle count is shortened to 20 clocks.
`timescale 1ns/1ps
module quad_xcvr_serial_mgmt_test;
    import qxsm_pkg::*;
    localparam logic [3:0] TB_DEV_ID = 4'h9; // Arbitrary value.
    localparam int RST_ITER = 3;
    localparam logic [21:0] CFG_DEF = 22'h03ffff;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_xcvr_rst_n = 1'b1;
    logic [21:0] cmd = 22'h000000;
    logic [11:0] stat = 12'h0f0;
    logic [3:0] txa = 4'h0;
    wire [21:0] cfg;
    wire [3:0] lpulse;
    logic [3:0] dev_id, link, pol, jab;
    logic valid, perr;
    int failures = 0;
    int checks_done = 0;
    logic [16:0] exp_q[$];

    qxsm_if link_bus ();

    qxsm_dev #(.LP_IDLE_CYC(20), .DEV_ID(TB_DEV_ID)) qxsm_dev_inst (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_xcvr_rst_n(i_xcvr_rst_n), .bus(link_bus.dev),
        .i_link_det(stat[11:8]), .i_pol_true(stat[7:4]),
        .i_jabber(stat[3:0]), .i_tx_act(txa),
        .o_ext_dist(cfg[21:18]), .o_link_test_en(cfg[17:14]),
        .o_link_pulse_en(cfg[13:10]), .o_auto_pol_dis(cfg[9:6]),
        .o_loopback_dis(cfg[5]), .o_mode_normal(cfg[4:1]),
        .o_pseudo_attach_levels(cfg[0]), .o_link_pulse(lpulse));

    qxsm_ctl qxsm_ctl_inst (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(1'b1),
        .bus(link_bus.ctl), .i_ext_dist(cmd[21:18]),
        .i_link_test_en(cmd[17:14]), .i_link_pulse_en(cmd[13:10]),
        .i_auto_pol_dis(cmd[9:6]), .i_loopback_dis(cmd[5]),
        .i_mode_normal(cmd[4:1]), .i_pseudo_attach_levels(cmd[0]),
        .o_dev_id(dev_id), .o_link(link), .o_pol(pol), .o_jab(jab),
        .o_status_valid(valid), .o_preamble_err(perr));

    qxsm_checker #(.DEV_ID(TB_DEV_ID)) qxsm_checker_inst (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_xcvr_rst_n(i_xcvr_rst_n), .dir(link_bus.dir),
        .dev_do(link_bus.dev_do), .dev_oe(link_bus.dev_oe),
        .ctl_do(link_bus.ctl_do), .ctl_oe(link_bus.ctl_oe),
        .mgmt_serial_line(link_bus.mgmt_serial_line));

    initial
    begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                want);
        end
    endtask

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_dir(input logic lvl);
        int n;
        n = 0;
        while (link_bus.dir !== lvl)
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
            if (n > 600)
            begin
                failures++;
                final_report();
            end
        end
    endtask

    // Registered outputs are read before this edge's updates land.
    always @(posedge i_ref_clk)
    begin
        if (valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check({dev_id, link, pol, jab, perr}, exp_q.pop_front());
        end
    end

    initial
    begin
        logic [3:0] got;
        logic [3:0] lp;
        void'($urandom(32'hc39f));
        // The low phase right after reset has no framing edge, so the
        // controller reads the pulled-up line and flags the preamble.
        exp_q.push_back(17'h1ffff);
        repeat (5) @(posedge i_ref_clk);
        #1;
        i_reset = 1'b0;
        check(cfg, CFG_DEF);
        for (int k = 0; k < 12; k++)
        begin
            wait_dir(1'b1);
            stat = 12'($urandom);
            // A device held in reset leaves the pulled-up line to be read.
            if (k == RST_ITER)
                exp_q.push_back(17'h1ffff);
            else
                exp_q.push_back({TB_DEV_ID, stat[11:8] | ~cmd[17:14],
                    stat[7:4], stat[3:0], 1'b0});
            wait_dir(1'b0);
            lp = (k == RST_ITER) ? 4'hf : cmd[13:10];
            if (k == RST_ITER)
            begin
                i_xcvr_rst_n = 1'b0;
                repeat (200) @(posedge i_ref_clk);
                #1;
                check(cfg, CFG_DEF);
                i_xcvr_rst_n = 1'b1;
            end
            else
                check(cfg, cmd);
            cmd = (k == 0) ? 22'h3fffff : 22'($urandom);
            txa = 4'($urandom);
            repeat (2) @(posedge i_ref_clk);
            got = 4'h0;
            repeat (60)
            begin
                @(posedge i_ref_clk);
                got = got | lpulse;
            end
            #1;
            check(got, lp & ~txa);
        end
        repeat (240) @(posedge i_ref_clk);
        #1;
        check(exp_q.size(), 0);
        final_report();
    end
endmodule
